// ### pkg/rsb_defs.vh
// Constants for the reset, strap and bus status block.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef RSB_DEFS_VH
`define RSB_DEFS_VH

// ==========
// Register offsets (byte addresses)
`define RSB_OFS_CTRL      8'h00
`define RSB_OFS_ADDR      8'h04
`define RSB_OFS_UP_CFG    8'h08
`define RSB_OFS_LOW_CFG   8'h0c
`define RSB_OFS_STATUS    8'h10

// ==========
// Field positions
`define RSB_CTRL_TYPE_LSB 0
`define RSB_CTRL_GO       8
`define RSB_CTRL_DMA      9
`define RSB_CTRL_LOCK     10
`define RSB_CTRL_RFSH     11
`define RSB_CTRL_PSRAM    12
`define RSB_CFG_SIZE_LSB  0
`define RSB_CFG_EN        6
`define RSB_CFG_SUPPRESS  7

// ==========
// Reset values and codes
`define RSB_RESET_VECTOR  20'hffff0
`define RSB_UP_CFG_RST    8'h00
`define RSB_LOW_CFG_RST   8'h00
`define RSB_ST_INTA       3'h0
`define RSB_ST_IO_RD      3'h1
`define RSB_ST_IO_WR      3'h2
`define RSB_ST_HALT       3'h3
`define RSB_ST_FETCH      3'h4
`define RSB_ST_MEM_RD     3'h5
`define RSB_ST_MEM_WR     3'h6
`define RSB_ST_PASSIVE    3'h7
`define RSB_RESP_OKAY     2'h0
`define RSB_RESP_SLVERR   2'h2

// ==========
// Timing: first fetch delay in tenths of output clock periods
`define RSB_FETCH_DELAY_X10 65
`define RSB_FETCH_HALF_PER  ((`RSB_FETCH_DELAY_X10 * 2 + 9) / 10)

`endif

// ### rtl/rsb_phase.v
// Bus cycle phase sequencer: idle, then phases one to four.
// Assumes tick pulses once per output clock period.
`timescale 1ns/1ns
module rsb_phase (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       tick,
    input  wire       start,
    input  wire       ready,
    output reg  [2:0] phase_q
);
    localparam IDLE = 3'h0;
    localparam T1   = 3'h1;
    localparam T2   = 3'h2;
    localparam T3   = 3'h3;
    localparam T4   = 3'h4;

    // ==========
    // Sequencer
    always @(posedge clk) begin
        if (rst) begin
            phase_q <= IDLE;
        end else if (ce && tick) begin
            case (phase_q)
                IDLE: phase_q <= start ? T1 : IDLE;
                T1:   phase_q <= T2;
                T2:   phase_q <= T3;
                // Wait states are inserted here until ready
                T3:   phase_q <= ready ? T4 : T3;
                T4:   phase_q <= IDLE;
                default: phase_q <= IDLE;
            endcase
        end
    end
endmodule // rsb_phase

// ### rtl/rsb_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes one clock, a synchronous active-high reset and a clock enable.
`timescale 1ns/1ns
module rsb_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    // ==========
    // Chain
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // First stage feeds the second stage only
    always @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else if (ce) begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // rsb_sync

// ### rtl/rsb_top.v
// Reset, strap sampling and bus cycle signalling with an AXI4-Lite slave.
// Assumes aclk at 10 MHz; pin inputs are asynchronous except sync_ready_in.
`timescale 1ns/1ns
`include "rsb_defs.vh"

// Summary of operation
// [RULE_01] Reset aborts work, clears state, vector FFFF0h
// [RULE_02] Source holds reset low at least 1 ms
// [RULE_03] Reset accepted anytime, synchronised before use
// [RULE_04] Clock runs over four periods during reset
// [RULE_05] First fetch about 6.5 periods after release
// [RULE_06] Strap high: suppress bit gates address phase
// [RULE_07] Strap low: address always driven, bits ignored
// [RULE_08] Address strap sampled one cycle after release
// [RULE_09] Refresh strobe low; psram uses alternate output
// [RULE_10] Refresh pin floats in hold and float mode
// [RULE_11] Three-bit cycle status encoding zero to seven
// [RULE_12] Status floats during bus hold
// [RULE_13] DMA flag high phases two to four
// [RULE_14] Lock low only in phase one
// [RULE_15] Half-clock strap low divides clock, PLL off
// [RULE_16] Sync ready used directly; low defers async ready
// [RULE_17] Upper select block up to 512 Kbytes
// [RULE_18] Upper select defaults to 64K at F0000h
// [RULE_19] Both float straps low float all pins; bus_lock_n, mid_select3_refresh and vector_zone_flag stay driven
// [RULE_20] Upper select held high during hold
// [RULE_21] Vector zone flag: top four bits zero
// [RULE_22] Flat address held for phases one to four
// [RULE_23] Reset pin passes two-flop synchroniser
module rsb_top (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        sys_reset_in_n,
    input  wire        addr_phase_strap,
    input  wire        half_clock_strap,
    input  wire        float_req_strap0,
    input  wire        float_req_strap1,
    input  wire        hold_req,
    input  wire        sync_ready_in,
    input  wire        async_ready_in,
    output reg         hold_ack,
    output reg         clock_out_a,
    output reg         pll_enable,
    output reg  [2:0]  cycle_status_code,
    output reg         cycle_status_oe,
    output reg         dma_cycle_flag,
    output reg         dma_cycle_oe,
    output reg         bus_lock_n,
    output reg  [19:0] flat_location_bus,
    output reg         flat_location_oe,
    output reg  [7:0]  high_loc_out,
    output reg         high_loc_oe,
    output reg         top_mem_select_n,
    output reg         top_mem_select_oe,
    output reg         low_mem_select_n,
    output reg         low_mem_select_oe,
    output reg         refresh_strobe_n,
    output reg         refresh_strobe_oe,
    output reg         mid_select3_refresh,
    output reg         vector_zone_flag
);
    localparam IDLE = 3'h0;
    localparam T1   = 3'h1;
    localparam T2   = 3'h2;
    localparam T4   = 3'h4;

    // ==========
    // Functions
    // Block of 64K << code at the top or bottom of the 1M space
    function blk_hit;
        input [3:0] seg;
        input [1:0] code;
        input       upper;
        reg   [4:0] span;
        begin
            span = 5'h01 << code;
            if (upper)
                blk_hit = ({1'b0, seg} >= (5'h10 - span));
            else
                blk_hit = ({1'b0, seg} < span);
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // ==========
    // Pin synchronisers and internal reset
    wire [6:0] pins_s;
    wire       rst_pin_s;
    wire       aphase_s;
    wire       half_s;
    wire       flt0_s;
    wire       flt1_s;
    wire       hold_s;
    wire       async_ready_in_s;
    rsb_sync #(
        .W (7)
    ) u_sync (
        .clk (aclk),
        .rst (~aresetn),
        .ce  (ce),
        .d   ({sys_reset_in_n, addr_phase_strap, half_clock_strap, float_req_strap0,
               float_req_strap1, hold_req, async_ready_in}),
        .q   (pins_s)
    ); // RULE_03 RULE_23
    assign {rst_pin_s, aphase_s, half_s, flt0_s, flt1_s, hold_s, async_ready_in_s} = pins_s;

    // The pin itself must stay low for 1 ms; no stretching is done here
    wire int_rst = ~aresetn | ~rst_pin_s; // RULE_01 RULE_02
    reg  rel_q;
    reg  rise_d1_q;
    wire rise = rst_pin_s & ~rel_q;

    // ==========
    // Straps
    reg addr_mode_q;
    reg half_q;
    reg float_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rel_q       <= 1'b0;
            rise_d1_q   <= 1'b0;
            addr_mode_q <= 1'b1;
            half_q      <= 1'b0;
            float_q     <= 1'b0;
        end else if (ce) begin
            rel_q     <= rst_pin_s;
            rise_d1_q <= rise;
            if (rise_d1_q)
                addr_mode_q <= aphase_s; // RULE_08
            if (rise) begin
                half_q  <= ~half_s; // RULE_15
                float_q <= ~flt0_s & ~flt1_s; // RULE_19
            end else if (!rst_pin_s) begin
                float_q <= 1'b0;
            end
        end
    end

    // ==========
    // Output clock; half mode halves its rate
    reg  div_q;
    wire half_tick = ~half_q | div_q; // RULE_15
    wire tick      = half_tick & clock_out_a;
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_q       <= 1'b0;
            clock_out_a <= 1'b0;
            pll_enable  <= 1'b1;
        end else if (ce) begin
            div_q      <= ~div_q;
            pll_enable <= ~half_q; // RULE_15
            if (half_tick)
                clock_out_a <= ~clock_out_a;
        end
    end

    // ==========
    // AXI4-Lite slave
    reg  [7:0]  awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_got_q;
    reg         w_got_q;
    reg  [31:0] rd_val;
    reg         rd_ok;
    wire        wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire        wr_ok   = (awaddr_q[7:2] <= 6'h04) && (awaddr_q[1:0] == 2'h0);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSB_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RSB_RESP_OKAY;
            s_axi_rdata   <= 32'h0000_0000;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q      <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RSB_RESP_OKAY : `RSB_RESP_SLVERR;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? `RSB_RESP_OKAY : `RSB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ==========
    // Configuration and cycle request registers
    reg  [19:0] addr_q;
    reg  [2:0]  type_q;
    reg         dma_q;
    reg         lock_q;
    reg         rfsh_q;
    reg         psram_q;
    reg         req_q;
    reg  [7:0]  up_cfg_q;
    reg  [7:0]  low_cfg_q;
    reg         boot_done_q;
    reg  [3:0]  boot_cnt_q;
    wire [2:0]  phase;
    wire [31:0] wr_word = merge(32'h0000_0000, wdata_q, wstrb_q);
    wire [31:0] addr_mrg = merge({12'h000, addr_q}, wdata_q, wstrb_q);
    wire        go      = wr_fire && awaddr_q == `RSB_OFS_CTRL && wr_word[`RSB_CTRL_GO];
    wire        start   = ~hold_ack & ~float_q & (~boot_done_q | req_q) & boot_cnt_q == `RSB_FETCH_HALF_PER;
    wire        take    = tick & phase == IDLE & start;

    always @(posedge aclk) begin
        if (int_rst) begin
            addr_q      <= 20'h00000;
            type_q      <= `RSB_ST_PASSIVE;
            dma_q       <= 1'b0;
            lock_q      <= 1'b0;
            rfsh_q      <= 1'b0;
            psram_q     <= 1'b0;
            req_q       <= 1'b0;
            up_cfg_q    <= `RSB_UP_CFG_RST; // RULE_18
            low_cfg_q   <= `RSB_LOW_CFG_RST;
            boot_done_q <= 1'b0;
            boot_cnt_q  <= 4'h0;
        end else if (ce) begin
            // Count half periods of the output clock before the first fetch
            if (half_tick && boot_cnt_q != `RSB_FETCH_HALF_PER)
                boot_cnt_q <= boot_cnt_q + 4'h1; // RULE_05
            if (take)
                boot_done_q <= 1'b1;
            if (take && boot_done_q)
                req_q <= 1'b0;
            // A request while one is pending is dropped, not queued
            if (go && !req_q) begin
                req_q <= 1'b1;
            end
            if (wr_fire && wr_ok) begin
                case (awaddr_q)
                    `RSB_OFS_CTRL: begin
                        if (!req_q) begin
                            type_q <= wdata_q[`RSB_CTRL_TYPE_LSB +: 3];
                            dma_q  <= wdata_q[`RSB_CTRL_DMA];
                            lock_q <= wdata_q[`RSB_CTRL_LOCK];
                            rfsh_q <= wdata_q[`RSB_CTRL_RFSH];
                        end
                        if (wstrb_q[1])
                            psram_q <= wdata_q[`RSB_CTRL_PSRAM];
                    end
                    `RSB_OFS_ADDR:    addr_q    <= addr_mrg[19:0];
                    `RSB_OFS_UP_CFG:  up_cfg_q  <= wstrb_q[0] ? wdata_q[7:0] : up_cfg_q;
                    `RSB_OFS_LOW_CFG: low_cfg_q <= wstrb_q[0] ? wdata_q[7:0] : low_cfg_q;
                    default: ;
                endcase
            end
        end
    end

    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h0000_0000;
        case (s_axi_araddr)
            `RSB_OFS_CTRL:    rd_val = {19'h00000, psram_q, rfsh_q, lock_q, dma_q, req_q, 5'h00, type_q};
            `RSB_OFS_ADDR:    rd_val = {12'h000, addr_q};
            `RSB_OFS_UP_CFG:  rd_val = {24'h000000, up_cfg_q};
            `RSB_OFS_LOW_CFG: rd_val = {24'h000000, low_cfg_q};
            `RSB_OFS_STATUS:  rd_val = {23'h000000, phase, hold_ack, float_q, half_q, addr_mode_q,
                                        boot_done_q, req_q | (phase != IDLE)};
            default:          rd_ok  = 1'b0;
        endcase
    end

    // ==========
    // Bus cycle
    wire rdy = sync_ready_in | async_ready_in_s; // RULE_16
    rsb_phase u_phase (
        .clk     (aclk),
        .rst     (int_rst),
        .ce      (ce),
        .tick    (tick),
        .start   (start),
        .ready   (rdy),
        .phase_q (phase)
    );

    reg  [19:0] cur_addr_q;
    reg  [2:0]  cur_type_q;
    reg         cur_dma_q;
    reg         cur_lock_q;
    reg         cur_rfsh_q;
    always @(posedge aclk) begin
        if (int_rst) begin
            cur_addr_q <= `RSB_RESET_VECTOR; // RULE_01
            cur_type_q <= `RSB_ST_FETCH;
            cur_dma_q  <= 1'b0;
            cur_lock_q <= 1'b0;
            cur_rfsh_q <= 1'b0;
            hold_ack   <= 1'b0;
        end else if (ce) begin
            if (take && boot_done_q) begin
                cur_addr_q <= addr_q;
                cur_type_q <= type_q;
                cur_dma_q  <= dma_q;
                cur_lock_q <= lock_q;
                cur_rfsh_q <= rfsh_q;
            end
            // Hold is granted only between cycles
            if (tick && phase == IDLE && !take)
                hold_ack <= hold_s;
        end
    end

    // ==========
    // Pin drivers
    wire act    = phase != IDLE;
    wire up_hit = blk_hit(cur_addr_q[19:16], up_cfg_q[`RSB_CFG_SIZE_LSB +: 2], 1'b1); // RULE_17
    wire lo_hit = low_cfg_q[`RSB_CFG_EN] & blk_hit(cur_addr_q[19:16], low_cfg_q[`RSB_CFG_SIZE_LSB +: 2], 1'b0);
    wire supp   = addr_mode_q & ((up_hit & up_cfg_q[`RSB_CFG_SUPPRESS]) |
                                 (lo_hit & low_cfg_q[`RSB_CFG_SUPPRESS])); // RULE_06 RULE_07
    wire nohold = ~float_q & ~hold_ack;
    wire drive  = nohold & ~int_rst;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cycle_status_code   <= `RSB_ST_PASSIVE;
            cycle_status_oe     <= 1'b0;
            dma_cycle_flag      <= 1'b0;
            dma_cycle_oe        <= 1'b0;
            bus_lock_n          <= 1'b1;
            flat_location_bus   <= `RSB_RESET_VECTOR;
            flat_location_oe    <= 1'b0;
            high_loc_out        <= 8'h00;
            high_loc_oe         <= 1'b0;
            top_mem_select_n    <= 1'b1;
            top_mem_select_oe   <= 1'b0;
            low_mem_select_n    <= 1'b1;
            low_mem_select_oe   <= 1'b0;
            refresh_strobe_n    <= 1'b1;
            refresh_strobe_oe   <= 1'b0;
            mid_select3_refresh <= 1'b1;
            vector_zone_flag    <= 1'b0;
        end else if (ce) begin
            cycle_status_code   <= (act && phase != T4) ? cur_type_q : `RSB_ST_PASSIVE; // RULE_11
            cycle_status_oe     <= nohold; // RULE_12 RULE_19
            dma_cycle_flag      <= act && phase >= T2 && cur_dma_q; // RULE_13
            dma_cycle_oe        <= drive; // RULE_13
            bus_lock_n          <= ~(phase == T1 && cur_lock_q); // RULE_14
            flat_location_bus   <= cur_addr_q; // RULE_22
            flat_location_oe    <= nohold;
            high_loc_out        <= cur_addr_q[15:8];
            high_loc_oe         <= drive && phase == T1 && !supp; // RULE_06 RULE_07
            top_mem_select_n    <= ~(act & up_hit); // RULE_17 RULE_18 RULE_20
            top_mem_select_oe   <= ~float_q & ~int_rst; // RULE_20
            low_mem_select_n    <= ~(act & lo_hit);
            low_mem_select_oe   <= drive;
            refresh_strobe_n    <= ~(act & cur_rfsh_q & ~psram_q); // RULE_09
            refresh_strobe_oe   <= drive; // RULE_10
            mid_select3_refresh <= ~(act & cur_rfsh_q & psram_q); // RULE_09
            vector_zone_flag    <= act & ~|cur_addr_q[19:16]; // RULE_21
        end
    end
endmodule // rsb_top

// ### testbench/rsb_chk_asserts.sv
// Checker on the bus status pins of rsb_top.
// Assumes ce stays high, so clock_out_a runs at aclk/2 or aclk/4.
`timescale 1ns/1ns
module rsb_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        hold_ack,
    input wire [2:0]  cycle_status_code,
    input wire        cycle_status_oe,
    input wire        dma_cycle_flag,
    input wire        dma_cycle_oe,
    input wire        bus_lock_n,
    input wire [19:0] flat_location_bus,
    input wire        top_mem_select_n,
    input wire        top_mem_select_oe,
    input wire        refresh_strobe_oe,
    input wire        vector_zone_flag,
    input wire        clock_out_a,
    input wire        pll_enable
);
    // ==========
    // Hold seen on two edges: oe lags the grant by one aclk
    reg  hold_q;
    wire held = hold_ack && hold_q;
    always @(posedge aclk) begin
        hold_q <= aresetn && hold_ack;
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_reset_vec: assert property (disable iff (1'b0)
        !aresetn |=> flat_location_bus == 20'hffff0 && cycle_status_code == 3'h7) else $error("bad reset state");
    a_status_hold: assert property (held |-> !cycle_status_oe)
        else $error("status driven in hold");
    a_top_sel_hold: assert property (held |-> top_mem_select_oe && top_mem_select_n)
        else $error("top select not high in hold");
    a_rfsh_hold: assert property (held |-> !refresh_strobe_oe)
        else $error("refresh driven in hold");
    a_dma_hold: assert property (held |-> !dma_cycle_oe)
        else $error("dma flag driven in hold");
    a_zone_flag: assert property (cycle_status_code != 3'h7 |->
        vector_zone_flag == (flat_location_bus[19:16] == 4'h0)) else $error("zone flag wrong");
    a_lock_phase1: assert property ($fell(bus_lock_n) |->
        (cycle_status_code != 3'h7) ##[1:4] bus_lock_n) else $error("lock too long");
    a_dma_not_t1: assert property ($past(cycle_status_code) == 3'h7 && cycle_status_code != 3'h7
        |-> !dma_cycle_flag) else $error("dma flag in first phase");
    a_clk_half: assert property ($rose(clock_out_a) && !pll_enable |=> clock_out_a ##1 !clock_out_a)
        else $error("half clock wrong");
endmodule // rsb_chk

bind rsb_top rsb_chk rsb_chk_i (.*);

// ### testbench/rsb_ext_mem.sv
// Far-side memory model answering bus cycles on sync ready.
// Assumes a cycle starts when cycle_status_code leaves passive.
`timescale 1ns/1ns
module rsb_ext_mem (
    input  wire       aclk,
    input  wire [2:0] cycle_status_code,
    input  wire [3:0] waits,
    output reg        sync_ready_in = 1'b1
);
    // ==========
    // Wait states: a slow part holds ready low for a while
    reg [3:0] cnt_q = 4'h0;
    reg [2:0] code_q = 3'h7;
    always @(posedge aclk) begin
        code_q <= cycle_status_code;
        if (code_q == 3'h7 && cycle_status_code != 3'h7) begin
            cnt_q <= waits;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
        sync_ready_in <= (cnt_q == 4'h0);
    end
endmodule // rsb_ext_mem

// ### testbench/tb.sv
// Self-checking bench for rsb_top over AXI4-Lite and pins.
// Assumes rsb_ext_mem drives sync ready; ce, wstrb, async ready tied.
`timescale 1ns/1ns
`include "rsb_defs.vh"
module tb;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         sys_reset_in_n = 1'b0;
    reg         addr_phase_strap = 1'b1;
    reg         half_clock_strap = 1'b1;
    reg         float_req_strap0 = 1'b1;
    reg         float_req_strap1 = 1'b1;
    reg         hold_req = 1'b0;
    reg  [7:0]  s_axi_awaddr = 8'h00;
    reg  [7:0]  s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg         s_axi_awvalid = 1'b0;
    reg         s_axi_wvalid = 1'b0;
    reg         s_axi_arvalid = 1'b0;
    reg         s_axi_bready = 1'b1;
    reg         s_axi_rready = 1'b1;
    reg  [3:0]  waits = 4'h0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_ready_in;
    wire        hold_ack, clock_out_a, pll_enable, cycle_status_oe, dma_cycle_flag, dma_cycle_oe, bus_lock_n;
    wire        flat_location_oe, high_loc_oe, top_mem_select_n, top_mem_select_oe, low_mem_select_n;
    wire        low_mem_select_oe, refresh_strobe_n, refresh_strobe_oe, mid_select3_refresh, vector_zone_flag;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [2:0]  cycle_status_code;
    wire [19:0] flat_location_bus;
    wire [7:0]  high_loc_out;
    integer     err_count = 0;
    integer     n_tests = 0;
    integer     i;
    reg  [31:0] d;
    reg  [1:0]  r;

    rsb_top rsb_top_i (.*, .ce(1'b1), .s_axi_wstrb(4'hf), .async_ready_in(1'b0));
    rsb_ext_mem rsb_ext_mem_i (.aclk(aclk), .cycle_status_code(cycle_status_code), .waits(waits),
        .sync_ready_in(sync_ready_in));

    // ==========
    // Clock, checks and bus tasks
    initial begin
        forever #50 aclk = ~aclk;
    end
    task stop_test;
        begin
            $display("checks %0d errors %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task tmo;
        begin
            err_count = err_count + 1;
            stop_test;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One access; valids guarded so none is assigned twice in a step
    task ax(input w, input [7:0] a, input [31:0] v);
        integer k;
        begin
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= v;
            s_axi_awvalid <= w;
            s_axi_wvalid <= w;
            s_axi_arvalid <= !w;
            for (k = 0; k < 50; k = k + 1) begin
                @(posedge aclk);
                if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
                if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
                if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
                if (s_axi_bvalid || s_axi_rvalid) k = 99;
            end
            if (k == 50) tmo;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end
    endtask

    // ==========
    // Scenarios
    task t_reset(input a_s, input h_s, input fa, input fb);
        integer k;
        begin
            sys_reset_in_n <= 1'b0;
            addr_phase_strap <= a_s;
            half_clock_strap <= h_s;
            float_req_strap0 <= fa;
            float_req_strap1 <= fb;
            repeat (10000) @(posedge aclk);
            sys_reset_in_n <= 1'b1;
            for (k = 0; k < 40 && cycle_status_code !== 3'h4; k = k + 1) @(posedge aclk);
            if (fa | fb) begin
                chk(k >= (h_s ? 13 : 26) && k <= (h_s ? 25 : 40), 1);
                chk(flat_location_bus, `RSB_RESET_VECTOR);
                chk({top_mem_select_n, vector_zone_flag}, 0);
            end else begin
                chk({cycle_status_oe, top_mem_select_oe, flat_location_oe, refresh_strobe_oe}, 0);
            end
            ax(0, `RSB_OFS_STATUS, 0);
            chk(d[4:2], {!(fa | fb), !h_s, a_s});
            chk(pll_enable, h_s);
        end
    endtask
    task t_cycle(input [2:0] c, input [19:0] a, input [12:0] x, input ead);
        integer k;
        reg     rf, ad;
        begin
            ax(1, `RSB_OFS_ADDR, {12'h000, a});
            ax(1, `RSB_OFS_CTRL, {19'h0, x} | 32'h100 | c);
            for (k = 0; k < 60 && cycle_status_code !== c; k = k + 1) @(posedge aclk);
            if (k == 60) tmo;
            rf = !refresh_strobe_n;
            ad = high_loc_oe;
            chk(vector_zone_flag, a[19:16] == 4'h0);
            chk(top_mem_select_n, a < 20'hf0000);
            for (k = 0; k < 60 && cycle_status_code !== 3'h7; k = k + 1) begin
                @(posedge aclk);
                rf = rf | !refresh_strobe_n;
                ad = ad | high_loc_oe;
            end
            chk(flat_location_bus, a);
            chk(high_loc_out, a[15:8]);
            chk({ad, rf}, {ead, x[11]});
        end
    endtask
    task t_hold;
        integer k;
        begin
            hold_req <= 1'b1;
            for (k = 0; k < 40 && hold_ack !== 1'b1; k = k + 1) @(posedge aclk);
            @(posedge aclk);
            chk({cycle_status_oe, dma_cycle_oe, refresh_strobe_oe, top_mem_select_oe, top_mem_select_n}, 3);
            hold_req <= 1'b0;
            for (i = 0; i < 40 && hold_ack !== 1'b0; i = i + 1) @(posedge aclk);
            if (k == 40 || i == 40) tmo;
        end
    endtask

    // ==========
    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset(1, 1, 1, 1);
        ax(0, `RSB_OFS_UP_CFG, 0);
        chk(d[7:0], `RSB_UP_CFG_RST);
        ax(0, 8'h20, 0);
        chk(r, `RSB_RESP_SLVERR);
        for (i = 0; i < 7; i = i + 1) begin
            waits <= i[0] ? 4'h3 : 4'h0;
            t_cycle(i, (i < 4) ? {i[3:0], 16'h0400} : {16'hf000, i[3:0]},
                i == 1 ? 13'h200 : i == 2 ? 13'h400 : i == 5 ? 13'h800 : 13'h0, 1);
        end
        ax(1, `RSB_OFS_UP_CFG, 32'h80);
        t_cycle(3'h4, `RSB_RESET_VECTOR, 13'h0, 0);
        t_hold;
        t_reset(0, 0, 1, 1);
        ax(1, `RSB_OFS_UP_CFG, 32'h80);
        t_cycle(3'h6, 20'hf8000, 13'h0, 1);
        t_reset(1, 1, 0, 0);
        stop_test;
    end
endmodule // tb
